// file: verilog/cal_switch_params.svh
// Constants of the calendar switch: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by name from the design files only.
`ifndef CAL_SWITCH_PARAMS_SVH
`define CAL_SWITCH_PARAMS_SVH

// Timing
`define CAL_CLK_PERIOD_NS 5
`define CAL_SECOND_NS 1000000000
`define CAL_CYCLES_PER_SEC (`CAL_SECOND_NS / `CAL_CLK_PERIOD_NS)

// Block count
`define CAL_MAX_BLOCKS 32

// Global registers
`define CAL_REG_DATE 32'h0000_0000
`define CAL_REG_TIME 32'h0000_0004
`define CAL_REG_STATUS 32'h0000_0008

// Per-block channel registers
`define CAL_BLK_BASE 32'h0000_0100
`define CAL_BLK_END 32'h0000_0900
`define CAL_SEL_ON 2'h0
`define CAL_SEL_OFF 2'h1
`define CAL_SEL_VIEW 2'h2

// Date pattern word fields
`define CAL_F_DAY_LSB 0
`define CAL_F_DAY_USED 7
`define CAL_F_MON_LSB 8
`define CAL_F_MON_USED 15
`define CAL_F_YEAR_LSB 16
`define CAL_F_YEAR_USED 23

// Time word fields
`define CAL_F_SEC_LSB 0
`define CAL_F_MIN_LSB 8
`define CAL_F_HOUR_LSB 16

// Status word fields
`define CAL_F_POWER 31

// Calendar range and reset date (2001-01-01 00:00:00)
`define CAL_YEAR_FIRST 7'h01
`define CAL_YEAR_LAST 7'h63
`define CAL_RESET_DAY 5'h01
`define CAL_RESET_MONTH 4'h1
`define CAL_RESET_YEAR 7'h01

`endif

// file: verilog/cal_switch_pkg.sv
// Types shared by the calendar switch files.
// Assumes nothing of its surroundings.
package cal_switch_pkg;

  // One on or off date; each field may be unused
  typedef struct packed {
    logic d_used;
    logic [4:0] day;
    logic m_used;
    logic [3:0] month;
    logic y_used;
    logic [6:0] year;
  } date_pat_t;

  // One channel: on date, off date, display flag
  typedef struct packed {
    date_pat_t on;
    date_pat_t off;
    logic view;
  } chan_cfg_t;

  // Current calendar position, year as 01..99 of the century
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } cal_now_t;

endpackage : cal_switch_pkg

// file: verilog/cal_clock.sv
// Running calendar clock, seconds to years, with software load.
// Assumes a single clock and a load pulse from the register file.
`timescale 1ns/100ps
`include "cal_switch_params.svh"

module cal_clock #(
  parameter int CYCLES_PER_SEC = `CAL_CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Load from software
  input wire logic load_date_i,
  input wire logic load_time_i,
  input wire cal_switch_pkg::cal_now_t load_val_i,
  // Calendar state
  output cal_switch_pkg::cal_now_t now_o,
  output logic midnight_o
);

  typedef struct packed {
    logic [31:0] div;
    cal_switch_pkg::cal_now_t now;
    logic midnight;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Days in a month; every year divisible by four is a leap year here
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
    unique case (m)
      4'h2: month_days = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
      default: month_days = 5'h1f;
    endcase
  endfunction : month_days

  // Second divider and calendar carry chain
  always_comb begin
    s_d = s_q;
    s_d.midnight = 1'b0;
    if (s_q.div == 32'(CYCLES_PER_SEC - 1)) begin
      s_d.div = 32'h0;
      s_d.now.second = s_q.now.second + 6'h01;
      if (s_q.now.second == 6'h3b) begin
        s_d.now.second = 6'h00;
        s_d.now.minute = s_q.now.minute + 6'h01;
        if (s_q.now.minute == 6'h3b) begin
          s_d.now.minute = 6'h00;
          s_d.now.hour = s_q.now.hour + 5'h01;
          if (s_q.now.hour == 5'h17) begin
            s_d.now.hour = 5'h00;
            s_d.midnight = 1'b1;
            s_d.now.day = s_q.now.day + 5'h01;
            if (s_q.now.day >= month_days(s_q.now.month, s_q.now.year)) begin
              s_d.now.day = 5'h01;
              s_d.now.month = s_q.now.month + 4'h1;
              if (s_q.now.month >= 4'hc) begin
                s_d.now.month = 4'h1;
                // Past the last day of 2099 the calendar starts over at 2001
                s_d.now.year = (s_q.now.year >= `CAL_YEAR_LAST) ? `CAL_YEAR_FIRST : s_q.now.year + 7'h01;
              end
            end
          end
        end
      end
    end else begin
      s_d.div = s_q.div + 32'h1;
    end
    // Software load; the clock keeps running regardless of main power
    if (load_date_i) begin
      s_d.now.year = load_val_i.year;
      s_d.now.month = load_val_i.month;
      s_d.now.day = load_val_i.day;
    end
    if (load_time_i) begin
      s_d.now.hour = load_val_i.hour;
      s_d.now.minute = load_val_i.minute;
      s_d.now.second = load_val_i.second;
      s_d.div = 32'h0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.now.year <= `CAL_RESET_YEAR;
      s_q.now.month <= `CAL_RESET_MONTH;
      s_q.now.day <= `CAL_RESET_DAY;
    end else begin
      s_q <= s_d;
    end
  end

  assign now_o = s_q.now;
  assign midnight_o = s_q.midnight;

endmodule : cal_clock

// file: verilog/chan_window.sv
// Decides whether today lies inside one channel's switching window.
// Assumes the next channel's settings are offered for two-channel periods.
`timescale 1ns/100ps

module chan_window (
  // Today
  input wire cal_switch_pkg::cal_now_t now_i,
  // Own and following channel
  input wire cal_switch_pkg::chan_cfg_t own_i,
  input wire cal_switch_pkg::chan_cfg_t next_i,
  input wire logic has_next_i,
  // Result
  output logic inside_o
);

  // Comparison key of used fields, year most significant
  function automatic logic [15:0] key(input cal_switch_pkg::date_pat_t m, input cal_switch_pkg::date_pat_t v);
    key = {m.y_used ? v.year : 7'h00, m.m_used ? v.month : 4'h0, m.d_used ? v.day : 5'h00};
  endfunction : key

  function automatic logic any_used(input cal_switch_pkg::date_pat_t p);
    any_used = p.d_used | p.m_used | p.y_used;
  endfunction : any_used

  cal_switch_pkg::date_pat_t today;
  logic single;
  logic paired;
  logic in_single;
  logic in_paired;
  logic [15:0] on_key;
  logic [15:0] off_key;
  logic [15:0] now_on;
  logic [15:0] now_off;

  // Today as a pattern with every field used
  assign today = '{1'b1, now_i.day, 1'b1, now_i.month, 1'b1, now_i.year};

  // One channel with both dates, or on here and off in the next channel
  assign single = any_used(own_i.on) & any_used(own_i.off);
  assign paired = any_used(own_i.on) & ~any_used(own_i.off) & has_next_i
    & ~any_used(next_i.on) & any_used(next_i.off);

  // Recurring: each used field lies in its own range, off field inclusive
  assign in_single = (!own_i.on.d_used || (today.day >= own_i.on.day && today.day <= own_i.off.day))
    && (!own_i.on.m_used || (today.month >= own_i.on.month && today.month <= own_i.off.month))
    && (!own_i.on.y_used || (today.year >= own_i.on.year && today.year <= own_i.off.year));

  // Continuous: whole date range, wrapping over the year end when reversed
  assign on_key = key(own_i.on, own_i.on);
  assign off_key = key(next_i.off, next_i.off);
  assign now_on = key(own_i.on, today);
  assign now_off = key(next_i.off, today);
  assign in_paired = (on_key > off_key) ? (now_on >= on_key || now_off <= off_key)
    : (now_on >= on_key && now_off <= off_key);

  assign inside_o = (single & in_single) | (paired & in_paired);

endmodule : chan_window

// file: verilog/calendar_switch_block.sv
// Top of the calendar switch: Wishbone register file, calendar clock and
// one contact per block.
// Assumes a classic Wishbone master and a main-power status level.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "cal_switch_params.svh"

module calendar_switch_block #(
  parameter int NUM_BLOCKS = `CAL_MAX_BLOCKS,
  parameter int CYCLES_PER_SEC = `CAL_CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Main power present
  input wire logic power_ok_i,
  // Switching contacts, one per block
  output logic [NUM_BLOCKS-1:0] calendar_switch_contact_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    cal_switch_pkg::chan_cfg_t [NUM_BLOCKS-1:0][3:0] cfg;
    logic [NUM_BLOCKS-1:0][3:0] level;
    logic [NUM_BLOCKS-1:0] contact;
    logic pwr;
    logic resync;
  } state_t;

  state_t s_q;
  state_t s_d;

  cal_switch_pkg::cal_now_t now;
  cal_switch_pkg::cal_now_t load_val;
  logic midnight;
  logic load_date;
  logic load_time;
  logic [NUM_BLOCKS-1:0][3:0] lvl;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[8*i +: 8] = wr[8*i +: 8];
      end
    end
  endfunction : merge

  // Date pattern to register word
  function automatic logic [31:0] pat_word(input cal_switch_pkg::date_pat_t p);
    pat_word = 32'h0;
    pat_word[`CAL_F_DAY_LSB +: 5] = p.day;
    pat_word[`CAL_F_DAY_USED] = p.d_used;
    pat_word[`CAL_F_MON_LSB +: 4] = p.month;
    pat_word[`CAL_F_MON_USED] = p.m_used;
    pat_word[`CAL_F_YEAR_LSB +: 7] = p.year;
    pat_word[`CAL_F_YEAR_USED] = p.y_used;
  endfunction : pat_word

  // Register word to date pattern
  function automatic cal_switch_pkg::date_pat_t word_pat(input logic [31:0] w);
    word_pat.day = w[`CAL_F_DAY_LSB +: 5];
    word_pat.d_used = w[`CAL_F_DAY_USED];
    word_pat.month = w[`CAL_F_MON_LSB +: 4];
    word_pat.m_used = w[`CAL_F_MON_USED];
    word_pat.year = w[`CAL_F_YEAR_LSB +: 7];
    word_pat.y_used = w[`CAL_F_YEAR_USED];
  endfunction : word_pat

  // Calendar clock, independent of main power
  cal_clock #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
  ) u_clock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_date_i(load_date),
    .load_time_i(load_time),
    .load_val_i(load_val),
    .now_o(now),
    .midnight_o(midnight)
  );

  // One window decision per channel; D has no following channel
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    for (genvar c = 0; c < 4; c++) begin : g_ch
      chan_window u_win (
        .now_i(now),
        .own_i(s_q.cfg[b][c]),
        .next_i(s_q.cfg[b][(c + 1) % 4]),
        .has_next_i(c < 3),
        .inside_o(lvl[b][c])
      );
    end
  end

  // Bus decode fields
  logic [31:0] rel;
  logic [4:0] blk;
  logic [1:0] ch;
  logic [1:0] rsel;
  logic in_blk;
  logic req;

  assign rel = wb_adr_i - `CAL_BLK_BASE;
  assign blk = rel[10:6];
  assign ch = rel[5:4];
  assign rsel = rel[3:2];
  assign in_blk = (wb_adr_i >= `CAL_BLK_BASE) && (wb_adr_i < `CAL_BLK_END)
    && (32'(blk) < 32'(NUM_BLOCKS)) && (rsel != 2'h3) && (wb_adr_i[1:0] == 2'h0);
  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // Software date and time loads, merged with the current value
  always_comb begin
    logic [31:0] dw;
    logic [31:0] tw;
    dw = merge({8'h00, 1'b0, now.year, 4'h0, now.month, 3'h0, now.day}, wb_dat_i, wb_sel_i);
    tw = merge({11'h000, now.hour, 2'h0, now.minute, 2'h0, now.second}, wb_dat_i, wb_sel_i);
    load_val = now;
    load_val.day = dw[`CAL_F_DAY_LSB +: 5];
    load_val.month = dw[`CAL_F_MON_LSB +: 4];
    load_val.year = dw[`CAL_F_YEAR_LSB +: 7];
    load_val.second = tw[`CAL_F_SEC_LSB +: 6];
    load_val.minute = tw[`CAL_F_MIN_LSB +: 6];
    load_val.hour = tw[`CAL_F_HOUR_LSB +: 5];
    load_date = req & wb_we_i & (wb_adr_i == `CAL_REG_DATE);
    load_time = req & wb_we_i & (wb_adr_i == `CAL_REG_TIME);
  end

  // Register file and contact evaluation
  always_comb begin
    logic rise;
    logic fall;
    logic [31:0] old;
    rise = 1'b0;
    fall = 1'b0;
    old = 32'h0;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.pwr = power_ok_i;

    // Wishbone access, one cycle answer; unmapped reads as zero
    if (req) begin
      s_d.ack = 1'b1;
      s_d.rdat = 32'h0;
      if (wb_adr_i == `CAL_REG_DATE) begin
        s_d.rdat = {8'h00, 1'b0, now.year, 4'h0, now.month, 3'h0, now.day};
      end else if (wb_adr_i == `CAL_REG_TIME) begin
        s_d.rdat = {11'h000, now.hour, 2'h0, now.minute, 2'h0, now.second};
      end else if (wb_adr_i == `CAL_REG_STATUS) begin
        s_d.rdat[`CAL_F_POWER] = s_q.pwr;
        s_d.rdat[NUM_BLOCKS-1:0] = s_q.contact;
      end else if (in_blk) begin
        unique case (rsel)
          `CAL_SEL_ON: old = pat_word(s_q.cfg[blk][ch].on);
          `CAL_SEL_OFF: old = pat_word(s_q.cfg[blk][ch].off);
          default: old = {31'h0, s_q.cfg[blk][ch].view};
        endcase
        s_d.rdat = old;
        if (wb_we_i) begin
          // Writes apply at once and the block keeps running
          unique case (rsel)
            `CAL_SEL_ON: s_d.cfg[blk][ch].on = word_pat(merge(old, wb_dat_i, wb_sel_i));
            `CAL_SEL_OFF: s_d.cfg[blk][ch].off = word_pat(merge(old, wb_dat_i, wb_sel_i));
            default: s_d.cfg[blk][ch].view = wb_sel_i[0] ? wb_dat_i[0] : old[0];
          endcase
        end
      end
      // A new date means the stored day levels are stale
      if (wb_we_i && (wb_adr_i == `CAL_REG_DATE)) begin
        s_d.resync = 1'b1;
      end
    end

    // Contacts: open without power, recomputed on return or resync, else midnight edges
    if (!power_ok_i) begin
      s_d.contact = '0;
    end else if (s_q.resync || !s_q.pwr) begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        s_d.contact[b] = |lvl[b];
      end
      s_d.level = lvl;
      s_d.resync = load_date; // A date landing in this cycle keeps its own recompute
    end else if (midnight) begin
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        rise = |(lvl[b] & ~s_q.level[b]);
        fall = |(~lvl[b] & s_q.level[b]);
        // First off wins even while another channel is still on
        if (fall) begin
          s_d.contact[b] = 1'b0;
        end else if (rise) begin
          s_d.contact[b] = 1'b1;
        end
      end
      s_d.level = lvl;
    end
  end

  // State register; display flags allow after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.resync <= 1'b1;
      for (int b = 0; b < NUM_BLOCKS; b++) begin
        for (int c = 0; c < 4; c++) begin
          s_q.cfg[b][c].view <= 1'b1;
        end
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign calendar_switch_contact_o = s_q.contact;

endmodule : calendar_switch_block

// file: bench/relay_load.sv
// Load on the switching contacts, as a device output relay would be.
// Assumes registered contact levels on the same clock.
`timescale 1ns/100ps

module relay_load #(
  parameter int NUM_BLOCKS = 32
) (
  // Clock
  input wire logic clk_i,
  // Contacts from the switch
  input wire logic [NUM_BLOCKS-1:0] contact_i,
  // Relay state
  output logic [NUM_BLOCKS-1:0] closed_o
);
  // Relay follows the contact one clock later, no logic between
  always_ff @(posedge clk_i) begin
    closed_o <= contact_i;
  end
endmodule : relay_load

// file: bench/calendar_switch_checker.sv
// Concurrent checks on the calendar switch ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module calendar_switch_checker #(
  parameter int NUM_BLOCKS = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Power and contacts
  input wire logic power_ok_i,
  input wire logic [NUM_BLOCKS-1:0] calendar_switch_contact_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Request present on the bus
  wire req = wb_cyc_i && wb_stb_i;

  // Bus answers
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high a second cycle");
  AST_ACK_ANSWER: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  AST_ACK_CAUSE: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  AST_UNMAPPED_ZERO: assert property (req && !wb_ack_o && !wb_we_i && wb_adr_i == 32'h0000000c |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  // Contacts after reset and around power loss
  AST_RESET_QUIET: assert property ($fell(rst_i) |-> !wb_ack_o && calendar_switch_contact_o == {NUM_BLOCKS{1'h0}})
    else $error("outputs active after reset");
  AST_POWER_OPEN: assert property (!power_ok_i |=> calendar_switch_contact_o == {NUM_BLOCKS{1'h0}})
    else $error("contact closed without power");
  AST_POWER_FROZEN: assert property (!power_ok_i [*3] |-> $stable(calendar_switch_contact_o))
    else $error("contact moved without power");
  AST_RISE_POWERED: assert property ($rose(calendar_switch_contact_o[0]) |-> $past(power_ok_i))
    else $error("contact closed after power loss");

  // Main scenarios reached
  cover property ($rose(calendar_switch_contact_o[0]));
  cover property ($fell(calendar_switch_contact_o[0]));
  cover property ($fell(power_ok_i));
  cover property (wb_ack_o && wb_we_i);
endmodule : calendar_switch_checker

bind calendar_switch_block calendar_switch_checker #(.NUM_BLOCKS(NUM_BLOCKS)) i_calendar_switch_checker (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .power_ok_i(power_ok_i),
  .calendar_switch_contact_o(calendar_switch_contact_o)
);

// file: bench/testbench.sv
// Testbench for the calendar switch: registers, windows, pairs, overlaps, power.
// Assumes the design built with two blocks and a second of four cycles.
`timescale 1ns/100ps

module testbench;
  // Design inputs, set at time zero
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic power_ok_i = 1'h1;
  // Design outputs
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] calendar_switch_contact_o;
  logic [1:0] relay_closed;
  int errors = 0;
  int comparisons = 0;

  // Clock, 5 ns period
  always #2.5 clk_i = ~clk_i;

  calendar_switch_block #(.NUM_BLOCKS(2), .CYCLES_PER_SEC(4)) i_calendar_switch_block (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .power_ok_i(power_ok_i),
    .calendar_switch_contact_o(calendar_switch_contact_o)
  );

  relay_load #(.NUM_BLOCKS(2)) i_relay_load (
    .clk_i(clk_i),
    .contact_i(calendar_switch_contact_o),
    .closed_o(relay_closed)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One classic bus cycle, held until ack; only the watchdog ends a hang
  task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat, output logic [31:0] data);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    data = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : bus

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    logic [31:0] data;
    bus(1'h1, adr, dat, data);
  endtask : wr

  task automatic rd(input logic [31:0] adr, input logic [31:0] exp);
    logic [31:0] data;
    bus(1'h0, adr, 32'h0, data);
    chk($sformatf("register %h", adr), data, exp);
  endtask : rd

  // On and off pattern of one channel
  task automatic cfg(input logic [31:0] adr, input logic [31:0] on, input logic [31:0] off);
    wr(adr, on);
    wr(adr + 32'h4, off);
  endtask : cfg

  // Clears every channel that the scenarios use
  task automatic clr();
    for (int c = 0; c < 4; c++) begin
      cfg(32'h100 + 32'h10 * c, 32'h0, 32'h0);
    end
    cfg(32'h170, 32'h0, 32'h0);
  endtask : clr

  // Jumps to 23:59:59 of a date, checks contacts before and after midnight
  task automatic step(input logic [31:0] date, input logic [1:0] pre, input logic [1:0] post);
    wr(32'h4, 32'h000c0000);
    wr(32'h0, date);
    wr(32'h4, 32'h00173b3b);
    chk("contact before midnight", {30'h0, calendar_switch_contact_o}, {30'h0, pre});
    repeat (12) @(posedge clk_i);
    chk("contact after midnight", {30'h0, calendar_switch_contact_o}, {30'h0, post});
  endtask : step

  task automatic test_reset_values();
    rd(32'h0, 32'h00010101);
    rd(32'h108, 32'h1);
    rd(32'h178, 32'h1);
    rd(32'h10c, 32'h0);
    rd(32'hc, 32'h0);
    wr(32'h108, 32'h0);
    rd(32'h108, 32'h0);
    chk("contacts", {30'h0, calendar_switch_contact_o}, 32'h0);
  endtask : test_reset_values

  task automatic test_years();
    cfg(32'h100, 32'h00880000, 32'h008c0000);
    rd(32'h100, 32'h00880000);
    step(32'h00070c1f, 2'h0, 2'h1);
    step(32'h000c0c1f, 2'h1, 2'h0);
    clr();
  endtask : test_years

  task automatic test_days_block_d();
    cfg(32'h170, 32'h00000082, 32'h00000099);
    step(32'h00090301, 2'h0, 2'h2);
    step(32'h00090319, 2'h2, 2'h0);
    clr();
  endtask : test_days_block_d

  task automatic test_day_month();
    cfg(32'h120, 32'h00008689, 32'h00008a90);
    step(32'h00090708, 2'h0, 2'h1);
    step(32'h00090710, 2'h1, 2'h0);
    step(32'h00090b08, 2'h0, 2'h0);
    clr();
  endtask : test_day_month

  task automatic test_pair_year_end();
    cfg(32'h100, 32'h00008c9f, 32'h0);
    cfg(32'h110, 32'h0, 32'h00008181);
    step(32'h00090c1e, 2'h0, 2'h1);
    step(32'h00090c1f, 2'h1, 2'h1);
    step(32'h000a0101, 2'h1, 2'h0);
    clr();
  endtask : test_pair_year_end

  // Two-channel full dates, same year in both channels
  task automatic test_pair_full();
    cfg(32'h100, 32'h008b8582, 32'h0);
    cfg(32'h110, 32'h0, 32'h008b8b81);
    step(32'h000b0501, 2'h0, 2'h1);
    step(32'h000b0b01, 2'h1, 2'h0);
    step(32'h000c0501, 2'h0, 2'h0);
    clr();
  endtask : test_pair_full

  task automatic test_overlap();
    cfg(32'h100, 32'h00000082, 32'h00000099);
    cfg(32'h110, 32'h0000008a, 32'h0000009e);
    step(32'h00090301, 2'h0, 2'h1);
    step(32'h00090309, 2'h1, 2'h1);
    step(32'h00090319, 2'h1, 2'h0);
    clr();
  endtask : test_overlap

  task automatic test_power();
    cfg(32'h100, 32'h00000082, 32'h00000099);
    step(32'h00090304, 2'h1, 2'h1);
    power_ok_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk("contact without power", {30'h0, calendar_switch_contact_o}, 32'h0);
    rd(32'h8, 32'h0);
    step(32'h00090301, 2'h0, 2'h0);
    rd(32'h0, 32'h00090302);
    power_ok_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("contact after power return", {30'h0, calendar_switch_contact_o}, 32'h1);
    chk("relay", {30'h0, relay_closed}, 32'h1);
    rd(32'h8, 32'h80000001);
    clr();
  endtask : test_power

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    test_reset_values();
    test_years();
    test_days_block_d();
    test_day_month();
    test_pair_year_end();
    test_pair_full();
    test_overlap();
    test_power();
    test_done();
  end

  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    #400000;
    errors++;
    test_done();
  end
endmodule : testbench
